// File: rtl/rsagc_avg.sv
`timescale 1ns/100ps
module rsagc_avg
	import rsagc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic clear_i,
	input wire rsagc_smp_t smp_i,
	input wire logic [2:0] sel_i,
	output logic [7:0] avg_o,
	output logic upd_o
);
	logic [7:0] hist [0:255];
	logic [7:0] wr_ptr_reg;
	logic [8:0] fill_reg;
	logic [15:0] sum_reg;
	logic [7:0] avg_reg;
	logic upd_reg;
	logic [2:0] sel_reg;
	logic [8:0] win;
	logic [7:0] oldest;
	logic [15:0] sum_next;
	logic restart;

	// window is 2 samples at code 0, doubling up to 256
	assign win = 9'h002 << sel_i;
	assign oldest = hist[wr_ptr_reg - win[7:0]];
	assign restart = clear_i || (sel_i != sel_reg);

	// drop the leaving sample only once the window is full
	always_comb begin
		sum_next = sum_reg + {8'h00, smp_i.level};
		if (fill_reg == win) begin
			sum_next = sum_next - {8'h00, oldest};
		end
	end

	// history memory holds no control state, so no reset
	always_ff @(posedge clk_i) begin
		if (smp_i.valid) begin
			hist[wr_ptr_reg] <= smp_i.level;
		end
	end

	// running sum and fill level; a new window size starts over
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_reg <= 8'h00;
			fill_reg <= 9'h000;
			sum_reg <= 16'h0000;
			sel_reg <= RSAGC_SEL_RST;
		end else if (restart) begin
			fill_reg <= 9'h000;
			sum_reg <= 16'h0000;
			sel_reg <= sel_i;
		end else if (smp_i.valid) begin
			wr_ptr_reg <= wr_ptr_reg + 8'h01;
			sum_reg <= sum_next;
			if (fill_reg != win) begin
				fill_reg <= fill_reg + 9'h001;
			end
		end
	end

	// mean published after each sample once the window is filled
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avg_reg <= 8'h00;
			upd_reg <= 1'b0;
		end else begin
			upd_reg <= 1'b0;
			if (!restart && smp_i.valid && (fill_reg + 9'h001 >= win)) begin
				// shift is widened so code 7 divides by 256 instead of wrapping to 0
				avg_reg <= 8'(sum_next >> (4'(sel_i) + 4'h1));
				upd_reg <= 1'b1;
			end
		end
	end

	assign avg_o = avg_reg;
	assign upd_o = upd_reg;
endmodule : rsagc_avg

// File: rtl/rsagc_gain.sv
`timescale 1ns/100ps
module rsagc_gain
	import rsagc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire rsagc_smp_t smp_i,
	input wire rsagc_thr_t thr_i,
	output logic [2:0] gain_o
);
	logic [2:0] gain_reg;
	logic [2:0] gain_next;

	// bigger level value means weaker input, so "pin <= thr" is "level >= thr"
	always_comb begin
		if (smp_i.level >= thr_i.one) begin
			gain_next = RSAGC_G1;
		end else if (smp_i.level >= thr_i.two) begin
			gain_next = RSAGC_G2;
		end else if (smp_i.level >= thr_i.three) begin
			gain_next = RSAGC_G3;
		end else if (smp_i.level >= thr_i.four) begin
			gain_next = RSAGC_G4;
		end else if (smp_i.level >= thr_i.five) begin
			gain_next = RSAGC_G5;
		end else begin
			gain_next = RSAGC_G6;
		end
	end

	// gain only moves on a real sample, so the amplifier is not chattering
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gain_reg <= RSAGC_G1;
		end else if (smp_i.valid) begin
			gain_reg <= gain_next;
		end
	end

	assign gain_o = gain_reg;
endmodule : rsagc_gain

// File: rtl/rsagc_pkg.sv
package rsagc_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] RSAGC_CTRL_OFS = 8'h00;
	localparam logic [7:0] RSAGC_TRIM_OFS = 8'h04;
	localparam logic [7:0] RSAGC_THR_A_OFS = 8'h08;
	localparam logic [7:0] RSAGC_THR_B_OFS = 8'h0C;
	localparam logic [7:0] RSAGC_STATUS_OFS = 8'h10;
	localparam logic [7:0] RSAGC_CAL_OFS = 8'h14;
	// control field positions
	localparam int RSAGC_CTRL_RX_EN_POS = 0;
	localparam int RSAGC_CTRL_PRE_EN_POS = 1;
	localparam int RSAGC_CTRL_STR_EN_POS = 2;
	localparam int RSAGC_CTRL_CAL_POS = 3;
	// trim field positions
	localparam int RSAGC_TRIM_OFS_POS = 0;
	localparam int RSAGC_TRIM_SEL_POS = 8;
	// status field positions
	localparam int RSAGC_ST_READ_POS = 0;
	localparam int RSAGC_ST_GAIN_POS = 8;
	localparam int RSAGC_ST_STATE_POS = 11;
	localparam int RSAGC_ST_VALID_POS = 13;
	localparam int RSAGC_ST_CAL_POS = 14;
	// values after reset
	localparam logic [3:0] RSAGC_CTRL_RST = 4'h0;
	localparam logic [4:0] RSAGC_TRIM_OFS_RST = 5'h00;
	localparam logic [2:0] RSAGC_SEL_RST = 3'h2;
	// level thresholds fall from one to five, as a larger level is a weaker input
	localparam logic [31:0] RSAGC_THR_A_RST = 32'h78_8C_A0_B4;
	localparam logic [15:0] RSAGC_THR_B_RST = 16'hB4_64;
	// calibration: sample count and expected reference reading
	localparam int RSAGC_CAL_LOG2 = 4;
	localparam logic [7:0] RSAGC_CAL_REF_CODE = 8'h50;
	// gain codes
	localparam logic [2:0] RSAGC_G1 = 3'h1;
	localparam logic [2:0] RSAGC_G2 = 3'h2;
	localparam logic [2:0] RSAGC_G3 = 3'h3;
	localparam logic [2:0] RSAGC_G4 = 3'h4;
	localparam logic [2:0] RSAGC_G5 = 3'h6;
	localparam logic [2:0] RSAGC_G6 = 3'h7;

	typedef enum logic [1:0] {RSAGC_RX_OFF, RSAGC_RX_ENABLED, RSAGC_RX_ACTIVE} rsagc_rx_t;

	// five level thresholds, in the sample's half-dB attenuation units
	typedef struct packed {
		logic [7:0] five;
		logic [7:0] four;
		logic [7:0] three;
		logic [7:0] two;
		logic [7:0] one;
	} rsagc_thr_t;

	// one level sample from the front end
	typedef struct packed {
		logic valid;
		logic [7:0] level;
	} rsagc_smp_t;
endpackage : rsagc_pkg

// File: rtl/rsagc_top.sv
`timescale 1ns/100ps
module rsagc_top
	import rsagc_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic SAMPLE_VALID_I,
	input wire logic [7:0] SAMPLE_LEVEL_I,
	input wire logic PREAMBLE_DETECT_I,
	output logic [2:0] FRONT_AMP_GAIN_CODE_O,
	output logic RX_ENABLED_O,
	output logic RX_ACTIVE_O,
	output logic CAL_BUSY_O
);
	rsagc_smp_t smp;
	rsagc_smp_t avg_smp;
	rsagc_thr_t thr;
	rsagc_rx_t state_reg;
	rsagc_rx_t state_next;
	logic [2:0] ctrl_reg;
	logic [4:0] trim_reg;
	logic [2:0] sel_reg;
	logic [31:0] thr_a_reg;
	logic [15:0] thr_b_reg;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic addr_phase;
	logic cal_busy_reg;
	logic [RSAGC_CAL_LOG2:0] cal_cnt_reg;
	logic [RSAGC_CAL_LOG2+7:0] cal_sum_reg;
	logic signed [8:0] cal_corr_reg;
	logic [7:0] avg;
	logic avg_upd;
	logic [7:0] reading_reg;
	logic reading_valid_reg;
	logic signed [10:0] comp;
	logic [2:0] gain;
	logic cal_start;
	logic str_hit;
	logic [RSAGC_CAL_LOG2+7:0] cal_sum_next;

	// byte offset of the addressed word; the low two address bits are not decoded,
	// so a byte or halfword access lands on its whole word
	function automatic logic [7:0] word_ofs(input logic [31:0] a);
		return {a[7:2], 2'b00};
	endfunction : word_ofs

	// both parts of a sample travel together to the gain stage
	assign smp = {SAMPLE_VALID_I, SAMPLE_LEVEL_I};
	// threshold five sits in the second word, below the strength detect level
	assign thr = {thr_b_reg[7:0], thr_a_reg};

	// ---- bus slave: zero wait states, always OKAY
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;
	assign HRDATA_O = rdata_reg;
	assign addr_phase = HSEL_I && HREADY_I && HTRANS_I[1];
	assign cal_start = wr_pend_reg && (wr_addr_reg == RSAGC_CTRL_OFS) &&
		HWDATA_I[RSAGC_CTRL_CAL_POS];

	// write address is held for the data phase that follows
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= addr_phase && HWRITE_I;
			if (addr_phase) begin
				wr_addr_reg <= word_ofs(HADDR_I);
			end
		end
	end

	// software-written configuration; unmapped writes fall through
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctrl_reg <= RSAGC_CTRL_RST[2:0];
			trim_reg <= RSAGC_TRIM_OFS_RST;
			sel_reg <= RSAGC_SEL_RST;
			thr_a_reg <= RSAGC_THR_A_RST;
			thr_b_reg <= RSAGC_THR_B_RST;
		end else if (wr_pend_reg) begin
			unique case (wr_addr_reg)
				RSAGC_CTRL_OFS: begin
					ctrl_reg <= HWDATA_I[RSAGC_CTRL_STR_EN_POS:RSAGC_CTRL_RX_EN_POS];
				end
				RSAGC_TRIM_OFS: begin
					trim_reg <= HWDATA_I[RSAGC_TRIM_OFS_POS+:5];
					sel_reg <= HWDATA_I[RSAGC_TRIM_SEL_POS+:3];
				end
				RSAGC_THR_A_OFS: begin
					thr_a_reg <= HWDATA_I;
				end
				RSAGC_THR_B_OFS: begin
					thr_b_reg <= HWDATA_I[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	// read data decoded in the address phase, registered into the data phase
	always_comb begin
		rdata_next = 32'h0000_0000;
		unique case (word_ofs(HADDR_I))
			RSAGC_CTRL_OFS: begin
				rdata_next[2:0] = ctrl_reg;
			end
			RSAGC_TRIM_OFS: begin
				rdata_next[RSAGC_TRIM_OFS_POS+:5] = trim_reg;
				rdata_next[RSAGC_TRIM_SEL_POS+:3] = sel_reg;
			end
			RSAGC_THR_A_OFS: begin
				rdata_next = thr_a_reg;
			end
			RSAGC_THR_B_OFS: begin
				rdata_next[15:0] = thr_b_reg;
			end
			RSAGC_STATUS_OFS: begin
				rdata_next[RSAGC_ST_READ_POS+:8] = reading_reg;
				rdata_next[RSAGC_ST_GAIN_POS+:3] = gain;
				rdata_next[RSAGC_ST_STATE_POS+:2] = state_reg;
				rdata_next[RSAGC_ST_VALID_POS] = reading_valid_reg;
				rdata_next[RSAGC_ST_CAL_POS] = cal_busy_reg;
			end
			RSAGC_CAL_OFS: begin
				rdata_next[8:0] = cal_corr_reg;
			end
			default: begin
			end
		endcase
	end

	// captured at the address edge, so a read right after a write sees the old value;
	// held until the next read so the master may sample it late
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rdata_reg <= 32'h0000_0000;
		end else if (addr_phase && !HWRITE_I) begin
			rdata_reg <= rdata_next;
		end
	end

	// capture total including the sample now arriving; 16 full-scale samples still fit
	assign cal_sum_next = cal_sum_reg + {{RSAGC_CAL_LOG2{1'b0}}, SAMPLE_LEVEL_I};

	// ---- calibration: average a reference tone and store the error
	// trade-off: a fixed short capture keeps the sequence quick but coarse
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cal_busy_reg <= 1'b0;
			cal_cnt_reg <= '0;
			cal_sum_reg <= '0;
			cal_corr_reg <= 9'sh000;
		end else if (cal_start) begin
			cal_busy_reg <= 1'b1;
			cal_cnt_reg <= '0;
			cal_sum_reg <= '0;
		end else if (cal_busy_reg && SAMPLE_VALID_I) begin
			cal_sum_reg <= cal_sum_next;
			cal_cnt_reg <= cal_cnt_reg + 1'b1;
			if (cal_cnt_reg == (RSAGC_CAL_LOG2+1)'(2 ** RSAGC_CAL_LOG2 - 1)) begin
				cal_busy_reg <= 1'b0;
				cal_corr_reg <= $signed({1'b0, RSAGC_CAL_REF_CODE}) -
					$signed({1'b0, 8'(cal_sum_next >> RSAGC_CAL_LOG2)});
			end
		end
	end

	// reference samples are kept out of the running average
	assign avg_smp = {SAMPLE_VALID_I && !cal_busy_reg, SAMPLE_LEVEL_I};

	rsagc_avg u_avg (
		.clk_i(CORE_CLK_I),
		.rst_n_i(RST_N_I),
		.clear_i(cal_start || !ctrl_reg[RSAGC_CTRL_RX_EN_POS]),
		.smp_i(avg_smp),
		.sel_i(sel_reg),
		.avg_o(avg),
		.upd_o(avg_upd)
	);

	rsagc_gain u_gain (
		.clk_i(CORE_CLK_I),
		.rst_n_i(RST_N_I),
		.smp_i(smp),
		.thr_i(thr),
		.gain_o(gain)
	);

	// mean plus whole-dB trim (two half-dB steps) plus calibration error
	assign comp = $signed({3'b000, avg}) + ($signed({{6{trim_reg[4]}}, trim_reg}) <<< 1) +
		$signed({{2{cal_corr_reg[8]}}, cal_corr_reg});

	// saturate so a large trim cannot wrap the reading around
	// trim is applied at the update, so a new trim shows only with the next sample
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			reading_reg <= 8'h00;
			reading_valid_reg <= 1'b0;
		end else if (!ctrl_reg[RSAGC_CTRL_RX_EN_POS]) begin
			reading_valid_reg <= 1'b0;
		end else if (avg_upd) begin
			reading_valid_reg <= 1'b1;
			if (comp < 0) begin
				reading_reg <= 8'h00;
			end else if (comp > 11'sd255) begin
				reading_reg <= 8'hFF;
			end else begin
				reading_reg <= comp[7:0];
			end
		end
	end

	// smaller reading means stronger input, so "at or below" is the hit
	assign str_hit = ctrl_reg[RSAGC_CTRL_STR_EN_POS] && reading_valid_reg &&
		(reading_reg <= thr_b_reg[15:8]);

	// ---- receive states
	// leaving receive always passes through off, so enabled is never entered from active
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			RSAGC_RX_OFF: begin
				if (ctrl_reg[RSAGC_CTRL_RX_EN_POS]) begin
					state_next = RSAGC_RX_ENABLED;
				end
			end
			RSAGC_RX_ENABLED: begin
				if (!ctrl_reg[RSAGC_CTRL_RX_EN_POS]) begin
					state_next = RSAGC_RX_OFF;
				end else if ((ctrl_reg[RSAGC_CTRL_PRE_EN_POS] && PREAMBLE_DETECT_I) ||
					str_hit) begin
					state_next = RSAGC_RX_ACTIVE;
				end
			end
			RSAGC_RX_ACTIVE: begin
				if (!ctrl_reg[RSAGC_CTRL_RX_EN_POS]) begin
					state_next = RSAGC_RX_OFF;
				end
			end
			default: begin
				state_next = RSAGC_RX_OFF;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_reg <= RSAGC_RX_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	assign RX_ENABLED_O = (state_reg == RSAGC_RX_ENABLED);
	assign RX_ACTIVE_O = (state_reg == RSAGC_RX_ACTIVE);
	assign CAL_BUSY_O = cal_busy_reg;
	assign FRONT_AMP_GAIN_CODE_O = gain;
endmodule : rsagc_top

// File: test/rsagc_bench.sv
`timescale 1ns/100ps
module rsagc_bench import rsagc_pkg::*;;
	logic clk;
	logic rst_n;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic s_valid;
	logic [7:0] s_level;
	logic pre;
	logic [2:0] gain;
	logic rx_en;
	logic rx_act;
	logic cal_busy;
	logic [31:0] v;
	int fails = 0;
	int n_compared = 0;

	rsagc_top dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
		.HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.SAMPLE_VALID_I(s_valid), .SAMPLE_LEVEL_I(s_level), .PREAMBLE_DETECT_I(pre),
		.FRONT_AMP_GAIN_CODE_O(gain), .RX_ENABLED_O(rx_en), .RX_ACTIVE_O(rx_act),
		.CAL_BUSY_O(cal_busy));
	rsagc_front_model fe (.clk_i(clk), .valid_o(s_valid), .level_o(s_level), .preamble_o(pre));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// address phase held until hready, data taken at the next hready edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		v = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, v);
	endtask : rdchk
	// status read lags the sample by two edges, so let it land first
	task automatic stat(input logic [31:0] m, input logic [31:0] e);
		repeat (2) @(posedge clk);
		bus(1'b0, RSAGC_STATUS_OFS, 32'h0);
		chk("status", e, v & m);
	endtask : stat
	task automatic st(input logic [1:0] e);
		#1 chk("rx_state", {30'h0, e}, {30'h0, rx_act, rx_en});
	endtask : st

	task automatic t_regs;
		rdchk("ctrl", RSAGC_CTRL_OFS, 32'h0);
		rdchk("trim", RSAGC_TRIM_OFS, 32'h200);
		rdchk("thr_a", RSAGC_THR_A_OFS, RSAGC_THR_A_RST);
		rdchk("thr_b", RSAGC_THR_B_OFS, {16'h0, RSAGC_THR_B_RST});
		wr(8'h18, 32'hFFFF_FFFF);
		rdchk("unmapped", 8'h18, 32'h0);
	endtask : t_regs
	// each threshold and the step beside it
	task automatic t_gain;
		logic [7:0] lv [10] = '{8'hB4, 8'hB3, 8'hA0, 8'h9F, 8'h8C, 8'h8B, 8'h78, 8'h77, 8'h64, 8'h63};
		logic [2:0] gc [10] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h6, 3'h6, 3'h7};
		for (int i = 0; i < 10; i++) begin
			fe.send(lv[i], 1);
			@(posedge clk);
			#1 chk("gain", {29'h0, gc[i]}, {29'h0, gain});
		end
	endtask : t_gain
	task automatic t_avg;
		wr(RSAGC_CTRL_OFS, 32'h1);
		wr(RSAGC_TRIM_OFS, 32'h0);
		fe.send(8'h28, 1);
		fe.send(8'h3C, 1);
		stat(32'h20FF, 32'h2032);
		fe.send(8'h50, 1);
		stat(32'h20FF, 32'h2046);
		// mean of -30 and -40 dBm read back as -35 dBm
		chk("level_dbm", 32'hFFFF_FFDD, 32'(-(int'(v[7:0])) / 2));
		wr(RSAGC_TRIM_OFS, 32'h3);
		fe.send(8'h46, 2);
		stat(32'h20FF, 32'h204C);
		wr(RSAGC_TRIM_OFS, 32'h10);
		fe.send(8'h46, 2);
		stat(32'h20FF, 32'h2026);
		wr(RSAGC_TRIM_OFS, 32'hF);
		fe.send(8'hFA, 2);
		stat(32'h20FF, 32'h20FF);
		// largest window: one sample short the old saturated reading still stands
		wr(RSAGC_TRIM_OFS, 32'h700);
		fe.send(8'hC8, 255);
		stat(32'h20FF, 32'h20FF);
		fe.send(8'hC8, 1);
		stat(32'h20FF, 32'h20C8);
	endtask : t_avg
	task automatic t_state;
		wr(RSAGC_CTRL_OFS, 32'h0);
		wr(RSAGC_TRIM_OFS, 32'h0);
		st(2'b00);
		wr(RSAGC_CTRL_OFS, 32'h1);
		@(posedge clk);
		st(2'b01);
		fe.set_pre(1'b1);
		repeat (3) @(posedge clk);
		st(2'b01);
		wr(RSAGC_CTRL_OFS, 32'h3);
		repeat (2) @(posedge clk);
		st(2'b10);
		fe.set_pre(1'b0);
		wr(RSAGC_CTRL_OFS, 32'h0);
		@(posedge clk);
		st(2'b00);
		wr(RSAGC_CTRL_OFS, 32'h5);
		fe.send(8'hC8, 2);
		repeat (4) @(posedge clk);
		st(2'b01);
		fe.send(8'h64, 1);
		repeat (4) @(posedge clk);
		st(2'b10);
	endtask : t_state
	// tone 6 below reference gives a correction of +6
	task automatic t_cal;
		wr(RSAGC_CTRL_OFS, 32'h9);
		@(posedge clk);
		#1 chk("cal_busy", 32'h1, {31'h0, cal_busy});
		fe.send(8'h4A, 16);
		repeat (2) @(posedge clk);
		#1 chk("cal_busy", 32'h0, {31'h0, cal_busy});
		rdchk("cal_corr", RSAGC_CAL_OFS, 32'h6);
		fe.send(8'h28, 1);
		fe.send(8'h3C, 1);
		stat(32'h20FF, 32'h2038);
	endtask : t_cal

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done

	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_gain();
		t_avg();
		t_state();
		t_cal();
		test_done();
	end
	// whole run needs under 1500 cycles
	initial begin
		repeat (4000) @(posedge clk);
		fails++;
		test_done();
	end
endmodule : rsagc_bench

// File: test/rsagc_front_model.sv
`timescale 1ns/100ps
module rsagc_front_model
	import rsagc_pkg::*;
(
	input wire logic clk_i,
	output logic valid_o,
	output logic [7:0] level_o,
	output logic preamble_o
);
	initial begin
		valid_o = 1'b0;
		level_o = 8'hA5;
		preamble_o = 1'b0;
	end
	// level is minus twice the input dBm; between samples the inverse shows so stale data is caught
	task automatic send(input logic [7:0] lvl, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			valid_o <= 1'b1;
			level_o <= lvl;
			@(posedge clk_i);
			valid_o <= 1'b0;
			level_o <= ~lvl;
		end
	endtask : send
	task automatic set_pre(input logic p);
		@(posedge clk_i);
		preamble_o <= p;
	endtask : set_pre
endmodule : rsagc_front_model

// File: test/rsagc_top_monitor.sv
`timescale 1ns/100ps
module rsagc_top_monitor
	import rsagc_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic HREADYOUT_O,
	input wire logic HRESP_O,
	input wire logic SAMPLE_VALID_I,
	input wire logic [2:0] FRONT_AMP_GAIN_CODE_O,
	input wire logic RX_ENABLED_O,
	input wire logic RX_ACTIVE_O,
	input wire logic CAL_BUSY_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);
	// zero-wait slave, never an error
	a_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
		else $error("bus answer not ready or not okay");
	// gain starts at full gain after reset
	a_gain_reset: assert property ($rose(RST_N_I) |-> FRONT_AMP_GAIN_CODE_O == 3'h1)
		else $error("gain not 001 after reset");
	a_gain_legal: assert property (!(FRONT_AMP_GAIN_CODE_O inside {3'h0, 3'h5}))
		else $error("gain code outside the six steps");
	// gain moves only on a sample
	a_gain_hold: assert property (!SAMPLE_VALID_I |=> $stable(FRONT_AMP_GAIN_CODE_O))
		else $error("gain changed without a sample");
	a_state_excl: assert property (!(RX_ENABLED_O && RX_ACTIVE_O))
		else $error("enabled and active together");
	a_enabled_first: assert property ($rose(RX_ENABLED_O) |-> !$past(RX_ACTIVE_O))
		else $error("enabled entered from active");
	a_active_entry: assert property ($rose(RX_ACTIVE_O) |-> $past(RX_ENABLED_O))
		else $error("active entered without enabled");
	// busy ends only when the last tone sample lands
	a_cal_hold: assert property (CAL_BUSY_O && !SAMPLE_VALID_I |=> CAL_BUSY_O)
		else $error("calibration ended without a sample");
endmodule : rsagc_top_monitor

bind rsagc_top rsagc_top_monitor u_mon (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
	.HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .SAMPLE_VALID_I(SAMPLE_VALID_I),
	.FRONT_AMP_GAIN_CODE_O(FRONT_AMP_GAIN_CODE_O), .RX_ENABLED_O(RX_ENABLED_O),
	.RX_ACTIVE_O(RX_ACTIVE_O), .CAL_BUSY_O(CAL_BUSY_O));
